// file: rtl/cdc_top.sv
// Digital control and output logic around one analog voltage comparator
// Overview of operation
// - Comparator runs only while cmp_on is set; cleared means lowest current.
// - With cmp_on at zero every comparator input is disconnected.
// - Disabled comparator reads as zero before polarity, so its output equals result_invert.
// - Result is readable as cmp_result and cmp_result_mirror, same value.
// - Internal result registered each instruction cycle; external path also registered, direct unless synced.
// - result_invert at 0 passes compare result; at 1 inverts it.
// - hysteresis_on set enables input hysteresis; clear disables it.
// - Sync mode captures result on falling edge of prescaled timer clock.
// - Timer counts on rising edges, opposite to the falling-edge capture.
// - Synchroniser uses only the primary timer clock source.
// - Rising and falling edges set cmp_irq_flag when their enable is set.
// - Flag stays until software clears it; a simultaneous edge wins.
// - Edge detectors work while disabled; polarity or enable toggles can flag.
// - Positive select: 7 ground, 6 fixed ref, 5 converter, 4-2 none, 1/0 pins.
// - Negative select: 7 ground, 6 fixed ref, 5-4 none, 3-0 negative pins.
// - Active result with shutdown source enabled suspends waveform generation at once.
`timescale 1ns/1ps
module cdc_top
  import cdc_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Control bits
  input wire logic cmp_on,
  input wire logic result_invert,
  input wire logic hysteresis_on,
  input wire logic sync_on,
  input wire logic rise_irq_on,
  input wire logic fall_irq_on,
  input wire logic [SEL_W-1:0] pos_input_sel,
  input wire logic [SEL_W-1:0] neg_input_sel,
  input wire logic irq_flag_clear,
  input wire logic wavegen_shutdown_src_on,
  // Analog core and timer
  input wire logic cmp_raw,
  input wire logic timer_clk_pre,
  // Analog core control
  output logic analog_power_on,
  output logic analog_hyst_on,
  output logic [PCONN_W-1:0] pos_connect,
  output logic [NCONN_W-1:0] neg_connect,
  // Results and events
  output logic cmp_result,
  output logic cmp_result_mirror,
  output logic cmp_ext_out,
  output logic cmp_irq_flag,
  output logic wavegen_shutdown
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic raw_s;
  logic tclk_s;

  cdc_sync2 u_sync_raw (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(clk_en),
    .d_async(cmp_raw),
    .q_sync(raw_s)
  );

  cdc_sync2 u_sync_tclk (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(clk_en),
    .d_async(timer_clk_pre),
    .q_sync(tclk_s)
  );

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [PCONN_W-1:0] pos_decode(input logic on, input logic [2:0] sel);
    logic [PCONN_W-1:0] v;
    v = RST_PCONN;
    if (on) begin
      unique case (sel)
        PSEL_GND: v[PC_GND] = 1'b1;
        PSEL_FREF: v[PC_FREF] = 1'b1;
        PSEL_DAC: v[PC_DAC] = 1'b1;
        PSEL_PIN1: v[PC_PIN1] = 1'b1;
        PSEL_PIN0: v[PC_PIN0] = 1'b1;
        default: v = RST_PCONN;
      endcase
    end
    return v;
  endfunction : pos_decode

  function automatic logic [NCONN_W-1:0] neg_decode(input logic on, input logic [2:0] sel);
    logic [NCONN_W-1:0] v;
    v = RST_NCONN;
    if (on) begin
      unique case (sel)
        NSEL_GND: v[NC_GND] = 1'b1;
        NSEL_FREF: v[NC_FREF] = 1'b1;
        NSEL_PIN3, NSEL_PIN2, NSEL_PIN1, NSEL_PIN0: v[NC_PIN0 + 32'(sel)] = 1'b1;
        default: v = RST_NCONN;
      endcase
    end
    return v;
  endfunction : neg_decode

  // ****************************************
  // State
  // ****************************************
  logic power_q;
  logic power_d;
  logic hyst_q;
  logic hyst_d;
  logic [PCONN_W-1:0] pconn_q;
  logic [PCONN_W-1:0] pconn_d;
  logic [NCONN_W-1:0] nconn_q;
  logic [NCONN_W-1:0] nconn_d;
  logic result_q;
  logic result_d;
  logic mirror_q;
  logic mirror_d;
  logic prev_q;
  logic prev_d;
  logic tclk_prev_q;
  logic tclk_prev_d;
  logic sync_val_q;
  logic sync_val_d;
  logic ext_q;
  logic ext_d;
  logic flag_q;
  logic flag_d;
  logic shut_q;
  logic shut_d;
  logic adj;
  logic rise_ev;
  logic fall_ev;
  logic tclk_fall;

  // ****************************************
  // Next values
  // ****************************************
  always_comb begin
    power_d = cmp_on;
    hyst_d = hysteresis_on;
    pconn_d = pos_decode(cmp_on, pos_input_sel);
    nconn_d = neg_decode(cmp_on, neg_input_sel);
    // Disabled core reads as zero before polarity
    adj = (cmp_on & raw_s) ^ result_invert;
    result_d = adj;
    mirror_d = adj;
    prev_d = result_q;
    rise_ev = result_q & ~prev_q;
    fall_ev = ~result_q & prev_q;
    // Set beats clear
    flag_d = (flag_q & ~irq_flag_clear) | (rise_ev & rise_irq_on) | (fall_ev & fall_irq_on);
    tclk_prev_d = tclk_s;
    tclk_fall = tclk_prev_q & ~tclk_s;
    sync_val_d = tclk_fall ? adj : sync_val_q;
    ext_d = sync_on ? sync_val_d : adj;
    shut_d = adj & wavegen_shutdown_src_on;
    if (!clk_en) begin
      power_d = power_q;
      hyst_d = hyst_q;
      pconn_d = pconn_q;
      nconn_d = nconn_q;
      result_d = result_q;
      mirror_d = mirror_q;
      prev_d = prev_q;
      flag_d = flag_q;
      tclk_prev_d = tclk_prev_q;
      sync_val_d = sync_val_q;
      ext_d = ext_q;
      shut_d = shut_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_q <= 1'b0;
      hyst_q <= 1'b0;
      pconn_q <= RST_PCONN;
      nconn_q <= RST_NCONN;
      result_q <= RST_RESULT;
      mirror_q <= RST_RESULT;
      prev_q <= RST_RESULT;
      flag_q <= RST_FLAG;
      tclk_prev_q <= 1'b0;
      sync_val_q <= RST_RESULT;
      ext_q <= RST_RESULT;
      shut_q <= 1'b0;
    end else begin
      power_q <= power_d;
      hyst_q <= hyst_d;
      pconn_q <= pconn_d;
      nconn_q <= nconn_d;
      result_q <= result_d;
      mirror_q <= mirror_d;
      prev_q <= prev_d;
      flag_q <= flag_d;
      tclk_prev_q <= tclk_prev_d;
      sync_val_q <= sync_val_d;
      ext_q <= ext_d;
      shut_q <= shut_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign analog_power_on = power_q;
  assign analog_hyst_on = hyst_q;
  assign pos_connect = pconn_q;
  assign neg_connect = nconn_q;
  assign cmp_result = result_q;
  assign cmp_result_mirror = mirror_q;
  assign cmp_ext_out = ext_q;
  assign cmp_irq_flag = flag_q;
  assign wavegen_shutdown = shut_q;

endmodule : cdc_top

// file: rtl/cdc_pkg.sv
// Package with constants for the comparator digital control block
package cdc_pkg;

  // ****************************************
  // Input select field
  // ****************************************
  localparam int unsigned SEL_W = 3;

  // Positive input select codes
  localparam logic [2:0] PSEL_GND = 3'h7;
  localparam logic [2:0] PSEL_FREF = 3'h6;
  localparam logic [2:0] PSEL_DAC = 3'h5;
  localparam logic [2:0] PSEL_PIN1 = 3'h1;
  localparam logic [2:0] PSEL_PIN0 = 3'h0;

  // Negative input select codes
  localparam logic [2:0] NSEL_GND = 3'h7;
  localparam logic [2:0] NSEL_FREF = 3'h6;
  localparam logic [2:0] NSEL_PIN3 = 3'h3;
  localparam logic [2:0] NSEL_PIN2 = 3'h2;
  localparam logic [2:0] NSEL_PIN1 = 3'h1;
  localparam logic [2:0] NSEL_PIN0 = 3'h0;

  // One-hot connection vector widths
  localparam int unsigned PCONN_W = 5;
  localparam int unsigned NCONN_W = 6;

  // Connection vector bit positions
  localparam int unsigned PC_PIN0 = 0;
  localparam int unsigned PC_PIN1 = 1;
  localparam int unsigned PC_DAC = 2;
  localparam int unsigned PC_FREF = 3;
  localparam int unsigned PC_GND = 4;
  localparam int unsigned NC_PIN0 = 0;
  localparam int unsigned NC_FREF = 4;
  localparam int unsigned NC_GND = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_RESULT = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [PCONN_W-1:0] RST_PCONN = 5'h00;
  localparam logic [NCONN_W-1:0] RST_NCONN = 6'h00;

endpackage : cdc_pkg

// file: rtl/cdc_sync2.sv
// Two-flop synchroniser for one level input
`timescale 1ns/1ps
module cdc_sync2 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Data
  input wire logic d_async,
  output logic q_sync
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // ****************************************
  // Next value
  // ****************************************
  always_comb begin
    meta_d = ce ? d_async : meta_q;
    sync_d = ce ? meta_q : sync_q;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_sync = sync_q;

endmodule : cdc_sync2

// file: sim/cdc_chk.sv
// Port checker for the comparator control block
`timescale 1ns/1ps
module cdc_chk
  import cdc_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Control bits
  input wire logic cmp_on,
  input wire logic hysteresis_on,
  input wire logic sync_on,
  input wire logic rise_irq_on,
  input wire logic irq_flag_clear,
  input wire logic wavegen_shutdown_src_on,
  input wire logic [SEL_W-1:0] pos_input_sel,
  // Block outputs
  input wire logic analog_power_on,
  input wire logic analog_hyst_on,
  input wire logic cmp_result,
  input wire logic cmp_result_mirror,
  input wire logic cmp_ext_out,
  input wire logic cmp_irq_flag,
  input wire logic wavegen_shutdown,
  input wire logic [PCONN_W-1:0] pos_connect,
  input wire logic [NCONN_W-1:0] neg_connect
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_mirror_same: assert property (cmp_result_mirror == cmp_result)
    else $error("mirror differs from result");
  a_power_follow: assert property ($past(clk_en && !rst) |->
    analog_power_on == $past(cmp_on))
    else $error("power control wrong");
  a_hyst_follow: assert property ($past(clk_en && !rst) |->
    analog_hyst_on == $past(hysteresis_on))
    else $error("hysteresis control wrong");
  a_off_open: assert property ($past(clk_en && !rst && !cmp_on) |->
    pos_connect == 5'h00 && neg_connect == 6'h00)
    else $error("inputs connected while off");
  a_pos_gnd: assert property ($past(clk_en && !rst && cmp_on && pos_input_sel == PSEL_GND) |->
    pos_connect == 5'h10)
    else $error("ground select wrong");
  a_rise_flag: assert property ($rose(cmp_result) && rise_irq_on && clk_en |-> ##[1:2] cmp_irq_flag)
    else $error("rise did not flag");
  a_flag_sticky: assert property (cmp_irq_flag && !irq_flag_clear && clk_en |=> cmp_irq_flag)
    else $error("flag lost");
  a_ext_direct: assert property ($past(clk_en && !rst && !sync_on) |->
    cmp_ext_out == cmp_result)
    else $error("direct output differs");
  a_shut_off: assert property ($past(clk_en && !rst && !wavegen_shutdown_src_on) |->
    !wavegen_shutdown)
    else $error("shutdown without source");
  a_shut_on: assert property (cmp_result && wavegen_shutdown_src_on && clk_en ##1
    cmp_result && wavegen_shutdown_src_on |-> wavegen_shutdown)
    else $error("shutdown missing");
  c_flag: cover property ($rose(cmp_irq_flag));
  c_shut: cover property ($rose(wavegen_shutdown));
  c_sync: cover property (sync_on && $changed(cmp_ext_out));
endmodule : cdc_chk
bind cdc_top cdc_chk i_chk (.clk_sys, .rst, .clk_en, .cmp_on, .hysteresis_on, .sync_on,
  .rise_irq_on, .irq_flag_clear, .wavegen_shutdown_src_on, .pos_input_sel, .analog_power_on,
  .analog_hyst_on, .cmp_result, .cmp_result_mirror, .cmp_ext_out, .cmp_irq_flag,
  .wavegen_shutdown, .pos_connect, .neg_connect);

// file: sim/cdc_core_mdl.sv
// Behavioural analog core and prescaled timer clock
`timescale 1ns/1ps
module cdc_core_mdl
  import cdc_pkg::*;
(
  input wire logic power_on,
  input wire logic [PCONN_W-1:0] pos_conn,
  input wire logic [NCONN_W-1:0] neg_conn,
  input wire logic vin_gt,
  input wire logic tmr_run,
  output logic cmp_raw,
  output logic timer_clk_pre
);
  // Powered down or open inputs give a low output
  // Input pins are taken as analog inputs with their drivers off
  assign cmp_raw = power_on && (|pos_conn) && (|neg_conn) && vin_gt;
  // Timer clock parked high while stopped
  initial timer_clk_pre = 1'b1;
  always #170 timer_clk_pre = tmr_run ? !timer_clk_pre : 1'b1;
endmodule : cdc_core_mdl

// file: sim/tb_cdc_top.sv
// Testbench for the comparator control block
`timescale 1ns/1ps
module tb_cdc_top
  import cdc_pkg::*;
;
  logic clk_sys, rst, clk_en, cmp_on, result_invert, hysteresis_on, sync_on, rise_irq_on;
  logic fall_irq_on, irq_flag_clear, wavegen_shutdown_src_on, vin_gt, tmr_run, seen;
  logic cmp_raw, timer_clk_pre, analog_power_on, analog_hyst_on, cmp_result;
  logic cmp_result_mirror, cmp_ext_out, cmp_irq_flag, wavegen_shutdown;
  logic [SEL_W-1:0] pos_input_sel, neg_input_sel;
  logic [PCONN_W-1:0] pos_connect;
  logic [NCONN_W-1:0] neg_connect;
  int err_count = 0;
  int num_checks = 0;
  // Rows: enable, invert, input above, expected result
  logic [3:0] rows [6] = '{4'hB, 4'h8, 4'hE, 4'hD, 4'h2, 4'h7};
  logic [7:0] pexp [8] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h04, 8'h08, 8'h10};
  logic [7:0] nexp [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h00, 8'h10, 8'h20};
  cdc_top i_dut (.clk_sys, .rst, .clk_en, .cmp_on, .result_invert, .hysteresis_on, .sync_on,
    .rise_irq_on, .fall_irq_on, .pos_input_sel, .neg_input_sel, .irq_flag_clear,
    .wavegen_shutdown_src_on, .cmp_raw, .timer_clk_pre, .analog_power_on, .analog_hyst_on,
    .pos_connect, .neg_connect, .cmp_result, .cmp_result_mirror, .cmp_ext_out,
    .cmp_irq_flag, .wavegen_shutdown);
  cdc_core_mdl i_mdl (.power_on(analog_power_on), .pos_conn(pos_connect),
    .neg_conn(neg_connect), .vin_gt, .tmr_run, .cmp_raw, .timer_clk_pre);
  always #20 clk_sys = !clk_sys;
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    #100us;
    err_count++;
    end_of_test;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    clk_sys = 0;
    rst = 1;
    clk_en = 1;
    wavegen_shutdown_src_on = 1;
    {cmp_on, result_invert, hysteresis_on, sync_on, rise_irq_on} = '0;
    {fall_irq_on, irq_flag_clear, vin_gt, tmr_run, pos_input_sel, neg_input_sel} = '0;
    step(9);
    chk(analog_power_on, 8'h00);
    chk(cmp_irq_flag, 8'h00);
    @(posedge clk_sys);
    rst <= 0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      {cmp_on, result_invert, vin_gt} <= rows[i][3:1];
      hysteresis_on <= rows[i][2];
      step(6);
      chk(cmp_result, rows[i][0]);
      chk(cmp_result_mirror, rows[i][0]);
      chk(cmp_ext_out, rows[i][0]);
      chk(wavegen_shutdown, rows[i][0]);
      chk(analog_hyst_on, rows[i][2]);
    end
    chk(cmp_irq_flag, 8'h00);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk_sys);
      cmp_on <= 1;
      pos_input_sel <= s[2:0];
      neg_input_sel <= s[2:0];
      step(2);
      chk(pos_connect, pexp[s]);
      chk(neg_connect, nexp[s]);
    end
    @(posedge clk_sys);
    {cmp_on, result_invert, pos_input_sel, neg_input_sel} <= '0;
    step(4);
    chk(pos_connect, 8'h00);
    chk(analog_power_on, 8'h00);
    @(posedge clk_sys);
    rise_irq_on <= 1;
    step(2);
    chk(cmp_irq_flag, 8'h00);
    @(posedge clk_sys);
    result_invert <= 1;
    step(14);
    chk(cmp_irq_flag, 8'h01);
    @(posedge clk_sys);
    irq_flag_clear <= 1;
    @(posedge clk_sys);
    irq_flag_clear <= 0;
    step(2);
    chk(cmp_irq_flag, 8'h00);
    // Falling edge arrives while the clear is held
    @(posedge clk_sys);
    {cmp_on, result_invert, vin_gt, irq_flag_clear, fall_irq_on} <= 5'h13;
    seen = 0;
    repeat (6) begin
      step(1);
      seen |= cmp_irq_flag;
    end
    chk(seen, 8'h01);
    @(posedge clk_sys);
    {sync_on, vin_gt, irq_flag_clear} <= 3'h4;
    step(6);
    vin_gt <= 1;
    step(6);
    chk(cmp_result, 8'h01);
    chk(cmp_ext_out, 8'h00);
    tmr_run <= 1;
    step(30);
    chk(cmp_ext_out, 8'h01);
    // Clock enable low freezes the result
    @(posedge clk_sys);
    clk_en <= 0;
    result_invert <= 1;
    step(4);
    chk(cmp_result, 8'h01);
    @(posedge clk_sys);
    clk_en <= 1;
    step(2);
    chk(cmp_result, 8'h00);
    // Reset in mid-run
    @(posedge clk_sys);
    rst <= 1;
    step(2);
    chk(cmp_result_mirror, 8'h00);
    chk(cmp_irq_flag, 8'h00);
    @(posedge clk_sys);
    rst <= 0;
    step(1);
    chk(analog_power_on, 8'h01);
    chk(cmp_irq_flag, 8'h00);
    end_of_test;
  end
endmodule : tb_cdc_top
